// ==== hw/wiper_master.sv ====
// Master end: sends START, address, command, data and STOP.
// Assumes the slave sits on the same link interface.
`timescale 1ns/10ps
`include "wiper_cfg.svh"
module wiper_master
    import wiper_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset,
    input  wire logic       i_clk_en,     // Freezes all state
    input  wire logic       i_req_valid,  // Start one transfer
    input  wire logic [6:0] i_req_addr,
    input  wire logic [7:0] i_req_cmd,
    input  wire logic [7:0] i_req_data,
    wiper_link_if.master    link,
    output logic            o_req_ready,  // Idle, request taken
    output logic            o_done,       // Transfer finished pulse
    output logic [2:0]      o_ack_bits    // Ack seen per byte, 1=acked
);
    master_state_t state_r;
    logic [7:0]  div_r;       // Half bit-period divider
    logic        phase_r;     // 0: clock high half, 1: low half
    logic [26:0] frame_r;     // Bits to send, ack slots as ones
    logic [4:0]  bit_r;       // Clock pulse index 0..27
    logic [1:0]  sda_sync_r;  // Data line synchroniser
    logic        scl_oe_r;
    logic        sda_oe_r;

    assign o_req_ready   = (state_r == MS_IDLE);
    assign link.scl_m_oe = scl_oe_r;
    assign link.sda_m_oe = sda_oe_r;
    wire tick = (div_r == `HALF_BIT_CYCLES);

    // Data line sampled through two flops for acks
    always_ff @(posedge i_clk_sys) begin
        if (i_reset)
            sda_sync_r <= 2'h3;
        else if (i_clk_en)
            sda_sync_r <= {sda_sync_r[0], link.sda};
    end

    // Sequencer: one half bit per tick
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_r    <= MS_IDLE;
            div_r      <= '0;
            phase_r    <= 1'b0;
            frame_r    <= '0;
            bit_r      <= '0;
            scl_oe_r   <= 1'b0;
            sda_oe_r   <= 1'b0;
            o_done     <= 1'b0;
            o_ack_bits <= '0;
        end else if (i_clk_en) begin
            o_done <= 1'b0;
            div_r  <= tick ? 8'h00 : div_r + 8'h01;
            case (state_r)
                MS_IDLE: begin
                    div_r <= '0;
                    if (i_req_valid) begin
                        frame_r <= {i_req_addr, 1'b0, 1'b1,
                                    i_req_cmd, 1'b1,
                                    i_req_data, 1'b1};
                        state_r <= MS_START;
                    end
                end
                MS_START: if (tick) begin
                    sda_oe_r <= 1'b1;
                    bit_r    <= '0;
                    phase_r  <= 1'b0;
                    state_r  <= MS_BITS;
                end
                MS_BITS: if (tick) begin
                    phase_r <= ~phase_r;
                    if (!phase_r) begin
                        // Clock low: drop clock and set data in the same cycle
                        scl_oe_r <= 1'b1;
                        sda_oe_r <= ~frame_r[26];
                        // Ack read at the end of its high phase: the
                        // slave answers a few cycles after the fall
                        if (bit_r == `ACK_END_ADDR ||
                            bit_r == `ACK_END_CMD)
                            o_ack_bits <= {o_ack_bits[1:0],
                                           ~sda_sync_r[1]};
                    end else begin
                        // Clock rises: advance to the next bit
                        scl_oe_r <= 1'b0;
                        frame_r  <= {frame_r[25:0], 1'b0};
                        bit_r    <= bit_r + 5'h01;
                        if (bit_r == `LAST_PULSE)
                            state_r <= MS_STOP;
                    end
                end
                MS_STOP: if (tick) begin
                    phase_r <= ~phase_r;
                    if (!phase_r) begin
                        scl_oe_r <= 1'b1;
                        sda_oe_r <= 1'b1;
                        // Ack of the data byte, read as its clock falls
                        o_ack_bits <= {o_ack_bits[1:0],
                                       ~sda_sync_r[1]};
                    end else begin
                        scl_oe_r <= 1'b0;
                        state_r  <= MS_DONE;
                    end
                end
                MS_DONE: if (tick) begin
                    sda_oe_r <= 1'b0;
                    o_done   <= 1'b1;
                    state_r  <= MS_IDLE;
                end
                default: state_r <= MS_IDLE;
            endcase
        end
    end
endmodule : wiper_master

// ==== hw/wiper_slave.sv ====
// Wiper slave end: receives address, command and data bytes and
// keeps the live and stored wiper registers.
// Assumes the link lines arrive asynchronously to i_clk_sys.
// Limitation: the link is oversampled, so each clock phase must
// last at least three i_clk_sys cycles; a faster master is missed.
// A frame cut before its last data bit leaves both wiper registers as they were.
`timescale 1ns/10ps
`include "wiper_cfg.svh"
module wiper_slave
    import wiper_pkg::*;
#(
    parameter logic [1:0] FIXED_ADDR_BITS = 2'h0 // Factory bits
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset,          // Power-on reset
    input  wire logic       i_clk_en,         // Freezes all state
    input  wire logic       i_addr_select_pin,
    wiper_link_if.slave     link,
    output logic [7:0]      o_wiper_live,     // Tap select
    output logic [7:0]      o_wiper_stored,   // Stored value
    output logic            o_init_done       // Power-up load done
);
    localparam int INIT_CYC = `INIT_CYCLES;

    logic [1:0]   scl_sync_r;    // Clock line synchroniser
    logic [1:0]   sda_sync_r;    // Data line synchroniser
    logic [1:0]   pin_sync_r;    // Address pin synchroniser
    logic         scl_d_r;       // Previous clock level
    logic         sda_d_r;       // Previous data level
    slave_state_t state_r;
    logic [3:0]   bit_cnt_r;     // 0..7 data bits, 8 = ack slot
    logic [7:0]   shift_r;       // Incoming byte
    logic [7:0]   cmd_r;         // Latched command
    logic         ack_r;         // Drives data low
    logic [8:0]   init_cnt_r;    // Power-up timer
    logic         armed_r;       // A clock rise seen since START
    // No reset and a power-up value: models the nonvolatile cell,
    // so a power-on reset never disturbs it
    logic [7:0]   stored_r = `STORED_RESET;

    // Synchronised levels and their edges, all on i_clk_sys
    wire scl_s    = scl_sync_r[1];
    wire sda_s    = sda_sync_r[1];
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
    // Own address: fixed nibble, factory bits, then the pin bit
    wire [6:0] own_addr = {`ADDR_HIGH_NIBBLE, FIXED_ADDR_BITS,
                           pin_sync_r[1]};

    // Phases in which clock edges move the bit counter
    function automatic logic in_frame(input slave_state_t st);
        in_frame = (st != SL_IDLE) && (st != SL_IGNORE);
    endfunction : in_frame

    // Last data bit of a byte: its falling clock closes the byte
    function automatic logic last_bit(input logic [3:0] cnt);
        last_bit = (cnt == `BITS_PER_BYTE - 4'h1);
    endfunction : last_bit

    // Received address byte names this device for a write
    function automatic logic addr_hit(input logic [7:0] byte_in,
                                      input logic [6:0] own);
        addr_hit = (byte_in == {own, 1'b0});
    endfunction : addr_hit

    // Falling clock that ends the eighth bit of any byte
    wire byte_end = scl_fall && armed_r && last_bit(bit_cnt_r);

    // Two flops on every outside input
    // Clock and data reset to idle high so no false edge follows reset; pin resets low
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            pin_sync_r <= 2'h0;
        end else if (i_clk_en) begin
            scl_sync_r <= {scl_sync_r[0], link.scl};
            sda_sync_r <= {sda_sync_r[0], link.sda};
            pin_sync_r <= {pin_sync_r[0], i_addr_select_pin};
        end
    end

    // Edge history, read only after the second flop
    // Idle high after reset, matching the released lines
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (i_clk_en) begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Power-up timer; bus ignored until the recall lands
    // Ending one count early keeps the load inside its time budget
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            init_cnt_r  <= '0;
            o_init_done <= 1'b0;
        end else if (i_clk_en && !o_init_done) begin
            init_cnt_r <= init_cnt_r + 9'h001;
            if (init_cnt_r == 9'(INIT_CYC - 2))
                o_init_done <= 1'b1;
        end
    end

    // Receive sequencer: bit count, shifting and phase
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_r   <= SL_IDLE;
            bit_cnt_r <= '0;
            shift_r   <= '0;
            cmd_r     <= '0;
            armed_r   <= 1'b0;
        end else if (i_clk_en && o_init_done) begin
            if (start_c) begin
                state_r   <= SL_ADDR;
                bit_cnt_r <= '0;
                // The clock fall that follows START carries no bit
                armed_r   <= 1'b0;
            end else if (stop_c) begin
                state_r <= SL_IDLE;
            end else if (scl_rise && in_frame(state_r)) begin
                armed_r <= 1'b1;
                if (bit_cnt_r < `ACK_BIT)
                    shift_r <= {shift_r[6:0], sda_s};
            end else if (scl_fall && armed_r && in_frame(state_r)) begin
                // Fall after the ack slot: on to the next phase
                if (bit_cnt_r == `ACK_BIT) begin
                    bit_cnt_r <= '0;
                    case (state_r)
                        SL_ADDR:  state_r <= SL_CMD;
                        SL_CMD:   state_r <= SL_DATA;
                        default:  state_r <= SL_IGNORE;
                    endcase
                end else begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (last_bit(bit_cnt_r)) begin
                        // Byte complete: check address, keep command
                        if (state_r == SL_ADDR &&
                            !addr_hit(shift_r, own_addr))
                            state_r <= SL_IGNORE;
                        // Command kept whole; unknown codes do nothing
                        if (state_r == SL_CMD)
                            cmd_r <= shift_r;
                    end
                end
            end
        end
    end

    // Acknowledge drive: low across the whole ninth clock
    always_ff @(posedge i_clk_sys) begin
        if (i_reset)
            ack_r <= 1'b0;
        else if (i_clk_en) begin
            if (start_c || stop_c)
                ack_r <= 1'b0;
            // Set on the fall that closes the eighth bit, so the
            // line is already low when the ninth clock rises
            else if (byte_end && o_init_done && (state_r == SL_CMD
                     || state_r == SL_DATA || (state_r == SL_ADDR
                     && addr_hit(shift_r, own_addr))))
                ack_r <= 1'b1;
            // Released on the fall that ends the ninth clock
            else if (scl_fall && bit_cnt_r == `ACK_BIT)
                ack_r <= 1'b0;
        end
    end
    // Open drain: the slave only ever pulls the line low
    assign link.sda_s_oe = ack_r;

    // Last data bit closed: the command acts now, not at STOP
    wire data_done = i_clk_en && o_init_done && byte_end &&
                     state_r == SL_DATA;

    // Stored register: survives the power-on reset model
    always_ff @(posedge i_clk_sys) begin
        if (data_done) begin
            if (cmd_r == `CMD_WRITE_STORED)
                stored_r <= shift_r;
            else if (cmd_r == `CMD_SAVE)
                stored_r <= o_wiper_live;
        end
    end
    // Output straight from the stored cell; no reset on purpose
    assign o_wiper_stored = stored_r;

    // Live register: lost on reset, reloaded from store
    always_ff @(posedge i_clk_sys) begin
        if (i_reset)
            o_wiper_live <= '0;
        else if (i_clk_en) begin
            // Copied every cycle of the load window, so the wiper
            // always starts from what the store holds now
            if (!o_init_done)
                o_wiper_live <= stored_r;
            // Live write and recall need a whole data byte; a frame cut
            // short before it leaves the live value alone
            else if (data_done && cmd_r == `CMD_WRITE_LIVE)
                o_wiper_live <= shift_r;
            else if (data_done && cmd_r == `CMD_RECALL)
                o_wiper_live <= stored_r;
        end
    end
endmodule : wiper_slave

// ==== shared/wiper_cfg.svh ====
// Constants shared by both ends of the two-wire wiper link.
// Assumes a 25 MHz system clock on each end and a slow serial clock.
`ifndef WIPER_CFG_SVH
`define WIPER_CFG_SVH
`define ADDR_HIGH_NIBBLE   4'h5
`define CMD_WRITE_LIVE     8'h11
`define CMD_WRITE_STORED   8'h21
`define CMD_RECALL         8'h61
`define CMD_SAVE           8'h51
`define STORED_RESET       8'h80
`define INIT_TIME_NS       10000
`define SYS_CLK_NS         40
`define INIT_CYCLES        ((`INIT_TIME_NS) / (`SYS_CLK_NS))
`define HALF_BIT_CYCLES    8'h04
`define BITS_PER_BYTE      4'h8
`define ACK_BIT            4'h8
// Master pulse counts: acks are read on the fall after these
`define ACK_END_ADDR       5'h09
`define ACK_END_CMD        5'h12
`define LAST_PULSE         5'h1A
`endif

// ==== shared/wiper_link_if.sv ====
// Two-wire link between the master end and the wiper slave end.
// Assumes pull-ups: a line is low when any enable is high.
`timescale 1ns/10ps
interface wiper_link_if;
    logic scl_m_oe;   // Master pulls clock low
    logic sda_m_oe;   // Master pulls data low
    logic sda_s_oe;   // Slave pulls data low
    logic scl;        // Resolved clock level
    logic sda;        // Resolved data level
    assign scl = ~scl_m_oe;
    assign sda = ~(sda_m_oe | sda_s_oe);
    modport master (output scl_m_oe, output sda_m_oe,
                    input scl, input sda);
    modport slave  (output sda_s_oe, input scl, input sda);
endinterface : wiper_link_if

// ==== shared/wiper_pkg.sv ====
// Types shared by both ends of the two-wire wiper link.
// Assumes the constants header is included by each user.
package wiper_pkg;
    // Slave receive phases
    typedef enum logic [2:0] {
        SL_IDLE, SL_ADDR, SL_CMD, SL_DATA, SL_IGNORE
    } slave_state_t;
    // Master sequencing phases
    typedef enum logic [2:0] {
        MS_IDLE, MS_START, MS_BITS, MS_STOP, MS_DONE
    } master_state_t;
endpackage : wiper_pkg

// ==== testbench/tb_top.sv ====
// Bench: master and slave ends joined by one link interface.
// Assumes both ends share the 25 MHz clock and the reset.
`timescale 1ns/10ps
`include "wiper_cfg.svh"
module tb_top;
    logic       i_clk_sys;
    logic       i_reset;
    logic       clk_en;    // Held high: run
    logic       req_valid;
    logic       pin;       // Address select level
    logic [6:0] req_addr;
    logic [7:0] req_cmd;
    logic [7:0] req_data;
    logic [7:0] live;
    logic [7:0] stored;
    logic       ready;
    logic       done;
    logic       init_done;
    logic [2:0] ack;
    int         errors;
    int         checks_done;
    wiper_link_if link ();
    wiper_master wiper_master_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_clk_en(clk_en), .i_req_valid(req_valid), .i_req_addr(req_addr),
        .i_req_cmd(req_cmd), .i_req_data(req_data), .link(link),
        .o_req_ready(ready), .o_done(done), .o_ack_bits(ack));
    wiper_slave #(.FIXED_ADDR_BITS(2'h1)) wiper_slave_i (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_clk_en(clk_en),
        .i_addr_select_pin(pin), .link(link), .o_wiper_live(live),
        .o_wiper_stored(stored), .o_init_done(init_done));
    wiper_link_assertions #(.FIXED_ADDR_BITS(2'h1)) wiper_link_assertions_i (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr_select_pin(pin),
        .scl_m_oe(link.scl_m_oe), .sda_m_oe(link.sda_m_oe),
        .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
    // 40 ns system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    task automatic wrap_up();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // Case equality so an unknown never matches
    task automatic chk(input string nm, input logic [7:0] ex, got);
        checks_done++;
        if (got !== ex) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // Reset, then time the load of the stored value
    task automatic pwr_up(input logic [7:0] es);
        int n;
        n = 0;
        i_reset <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        chk("live_clear", 8'h00, live);
        i_reset <= 1'b0;
        while (init_done !== 1'b1 && n < 300) begin
            @(posedge i_clk_sys);
            n++;
        end
        // A load that never ends closes the run
        if (n >= 300) begin
            errors++;
            wrap_up();
        end else begin
            chk("init_late", 8'h00, {7'h00, n > `INIT_CYCLES});
            chk("live_load", es, live);
        end
    endtask : pwr_up
    // One whole frame; valid held one edge, the master is idle
    task automatic xfer(input logic [6:0] a, input logic [7:0] c, d,
                        input logic [2:0] ea, input logic [7:0] el, es);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        chk("ready", 8'h01, {7'h00, ready});
        req_addr  <= a;
        req_cmd   <= c;
        req_data  <= d;
        req_valid <= 1'b1;
        @(posedge i_clk_sys);
        req_valid <= 1'b0;
        while (done !== 1'b1 && n < 1000) begin
            @(posedge i_clk_sys);
            n++;
        end
        // A hang ends the run at once
        if (n >= 1000) begin
            errors++;
            wrap_up();
        end else begin
            chk("ack_bits", {5'h00, ea}, {5'h00, ack});
            chk("live", el, live);
            chk("stored", es, stored);
        end
    endtask : xfer
    // Main sequence
    initial begin
        errors      = 0;
        checks_done = 0;
        i_reset     = 1'b1;
        clk_en      = 1'b1;
        req_valid   = 1'b0;
        pin         = 1'b0;
        req_addr    = 7'h00;
        req_cmd     = 8'h00;
        req_data    = 8'h00;
        pwr_up(8'h80);
        xfer(7'h2A, `CMD_WRITE_LIVE, 8'h00, 3'h7, 8'h00, 8'h80);
        xfer(7'h2A, `CMD_WRITE_LIVE, 8'hFF, 3'h7, 8'hFF, 8'h80);
        xfer(7'h2A, `CMD_WRITE_STORED, 8'h3C, 3'h7, 8'hFF, 8'h3C);
        xfer(7'h2A, `CMD_RECALL, 8'hA5, 3'h7, 8'h3C, 8'h3C);
        xfer(7'h2A, `CMD_WRITE_LIVE, 8'h5A, 3'h7, 8'h5A, 8'h3C);
        xfer(7'h2A, `CMD_SAVE, 8'h00, 3'h7, 8'h5A, 8'h5A);
        xfer(7'h2B, `CMD_WRITE_LIVE, 8'h01, 3'h0, 8'h5A, 8'h5A);
        xfer(7'h28, `CMD_WRITE_LIVE, 8'h02, 3'h0, 8'h5A, 8'h5A);
        xfer(7'h6A, `CMD_WRITE_LIVE, 8'h03, 3'h0, 8'h5A, 8'h5A);
        pin <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        xfer(7'h2B, `CMD_WRITE_LIVE, 8'h81, 3'h7, 8'h81, 8'h5A);
        xfer(7'h2A, `CMD_WRITE_LIVE, 8'h04, 3'h0, 8'h81, 8'h5A);
        pwr_up(8'h5A);
        wrap_up();
    end
endmodule : tb_top

// ==== testbench/wiper_link_assertions.sv ====
// Checker for the two-wire wiper link, fed from the interface lines.
// Assumes the master end holds SCL low and high five cycles each.
`timescale 1ns/10ps
`include "wiper_cfg.svh"
module wiper_link_assertions #(
    parameter logic [1:0] FIXED_ADDR_BITS = 2'h0 // Factory bits
) (
    input  wire logic i_clk_sys,
    input  wire logic i_reset,
    input  wire logic i_addr_select_pin,
    input  wire logic scl_m_oe,
    input  wire logic sda_m_oe,
    input  wire logic sda_s_oe,
    input  wire logic scl,
    input  wire logic sda
);
    logic       scl_q;  // Clock level one cycle back
    logic       sda_q;  // Data level one cycle back
    logic       busy_r; // Between START and STOP
    logic [4:0] cnt_r;  // Clock pulses since START
    logic [7:0] sh_r;   // Bits taken on each clock rise
    logic [7:0] own;    // Own address with write bit
    logic       rise;
    logic       start;
    logic       stop;
    assign own   = {`ADDR_HIGH_NIBBLE, FIXED_ADDR_BITS, i_addr_select_pin, 1'b0};
    assign rise  = scl & ~scl_q;
    assign start = scl & scl_q & sda_q & ~sda;
    assign stop  = scl & scl_q & ~sda_q & sda;
    // Line history; one shared clock, so no synchroniser
    always_ff @(posedge i_clk_sys) begin
        scl_q <= scl;
        sda_q <= sda;
    end
    // Frame tracking
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            busy_r <= 1'b0;
        end else if (start) begin
            busy_r <= 1'b1;
        end else if (stop) begin
            busy_r <= 1'b0;
        end
    end
    // Pulse count and shift; count restarts on every START
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || start) begin
            cnt_r <= 5'h00;
        end else if (rise) begin
            cnt_r <= cnt_r + 5'h01;
            sh_r  <= {sh_r[6:0], sda};
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    a_ack_moves_low: assert property (
        $changed(sda_s_oe) |-> !scl) else $error("ack moved, clock high");
    a_ack_whole_high: assert property (
        rise && sda_s_oe |-> sda_s_oe [*5])
        else $error("ack dropped in high phase");
    a_ack_slot_only: assert property (
        rise && sda_s_oe |-> cnt_r inside {5'h08, 5'h11, 5'h1A})
        else $error("slave pulled data outside ack slot");
    a_match_acks: assert property (
        rise && cnt_r == 5'h08 && sh_r == own |-> sda_s_oe)
        else $error("own address not acked");
    a_mismatch_silent: assert property (
        rise && cnt_r == 5'h08 && sh_r != own |-> !sda_s_oe [*8])
        else $error("foreign address acked");
    a_idle_lines_free: assert property (
        !busy_r |-> !sda_s_oe && !scl_m_oe)
        else $error("line pulled while bus idle");
    a_frame_pulse_count: assert property (
        stop && busy_r |-> cnt_r == 5'h1C) // 27 bits plus STOP rise
        else $error("frame pulse count wrong");
    a_ack_bounded: assert property (
        $rose(sda_s_oe) |-> sda_s_oe [*6] ##[1:8] !sda_s_oe)
        else $error("ack length wrong");
    a_master_frees_ack: assert property (
        rise && cnt_r inside {5'h08, 5'h11, 5'h1A} |-> !sda_m_oe)
        else $error("master drove data in ack slot");
    cover property (stop && busy_r);
    cover property (rise && cnt_r == 5'h08 && sh_r != own);
    cover property (rise && cnt_r == 5'h1A && sda_s_oe);
endmodule : wiper_link_assertions
